// ### frirq_pkg.sv
// Purpose: constants and types for the frame rate inquiry register bank
// Assumes: 32-bit AXI4-Lite register access, 12-bit byte offsets
// Notes:   capability tables are fixed; index 0 is the lowest offset
package frirq_pkg;

    // address and data widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NCAP   = 6;
    localparam int CNT_W  = 8;

    // capability register offsets, index 0 last in the list
    localparam logic [NCAP-1:0][ADDR_W-1:0] CAP_OFS = {
        12'h238, 12'h234, 12'h228, 12'h218, 12'h214, 12'h204
    };

    // one availability bit per rate, bit 0 = 1.875 fps .. bit 7 = 240 fps
    localparam logic [NCAP-1:0][7:0] CAP_VAL = {
        8'h1e, 8'h1e, 8'h3c, 8'h1f, 8'h3f, 8'h3f
    };

    // block control and status
    localparam logic [ADDR_W-1:0] CTRL_OFS     = 12'h300;
    localparam logic [ADDR_W-1:0] STAT_OFS     = 12'h304;
    localparam int                CTRL_ERR_BIT = 0;
    localparam logic              CTRL_RESET   = 1'b1;
    localparam logic [CNT_W-1:0]  STAT_RESET   = 8'h00;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // read answer carrier
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0]        resp;
    } frirq_rd_type;

    // channel states
    typedef enum {W_COLLECT, W_RESP} frirq_wst_type;
    typedef enum {R_IDLE, R_RESP} frirq_rst_type;

endpackage

// ### frirq_regs.sv
// Purpose: read-only frame rate capability bank behind an AXI4-Lite slave
// Assumes: MCLK_I at 100 MHz, all bus inputs synchronous to it
// Notes:   one write and one read in flight at most; no byte lanes on reads
// Functional notes
// RQ1: one bit per format, mode and rate
// RQ2: bit one means supported, zero unsupported
// RQ3: bits 0..7 are 1.875 to 240 fps
// RQ4: offset 0x204 reports rates 0..5 available
// RQ5: offset 0x214 reports rates 0..5 available
// RQ6: offset 0x218 reports rates 0..4 available
// RQ7: offset 0x228 reports rates 2..5 available
// RQ8: offset 0x234 reports rates 1..4 available
// RQ9: offset 0x238 reports rates 1..4 available
// RQ10: bits 8..31 always read as zero
// RQ11: writes to capability registers are ignored
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module frirq_regs
    import frirq_pkg::*;
(
    // clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RESETN_I,
    // write address channel
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    // write data channel
    input  wire logic [DATA_W-1:0] S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    // write response channel
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    // read address channel
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    // read data channel
    output logic [DATA_W-1:0]      S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I
);

    // reset synchroniser: asserts at once, releases after two edges
    logic [1:0] rst_sync_q;
    logic       rst_n_s;

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_q[1];

    // write channel state
    frirq_wst_type      wst_q, wst_d;
    logic               aw_got_q, aw_got_d;
    logic               w_got_q, w_got_d;
    logic [ADDR_W-1:0]  waddr_q, waddr_d;
    logic [DATA_W-1:0]  wdata_q, wdata_d;
    logic [3:0]         wstrb_q, wstrb_d;
    logic [1:0]         bresp_q, bresp_d;
    logic               ctrl_err_q, ctrl_err_d;
    logic [CNT_W-1:0]   ign_cnt_q, ign_cnt_d;

    // read channel state
    frirq_rst_type      rst_q, rst_d;
    frirq_rd_type       rd_q, rd_d;
    logic [ADDR_W-3:0]  rd_word_q, rd_word_d;

    // decode helpers
    logic               aw_fire, w_fire, wr_go, cap_wr_evt;
    logic [ADDR_W-1:0]  waddr_eff;
    logic [DATA_W-1:0]  wdata_eff;
    logic [3:0]         wstrb_eff;
    logic [NCAP-1:0]    cap_hit_w, cap_hit_r;

    // handshake outputs follow the channel states
    assign S_AXI_AWREADY_O = (wst_q == W_COLLECT) && !aw_got_q;
    assign S_AXI_WREADY_O  = (wst_q == W_COLLECT) && !w_got_q;
    assign S_AXI_BVALID_O  = (wst_q == W_RESP);
    assign S_AXI_BRESP_O   = bresp_q;
    assign S_AXI_ARREADY_O = (rst_q == R_IDLE);
    assign S_AXI_RVALID_O  = (rst_q == R_RESP);
    assign S_AXI_RDATA_O   = rd_q.data;
    assign S_AXI_RRESP_O   = rd_q.resp;

    assign aw_fire   = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign w_fire    = S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign waddr_eff = aw_got_q ? waddr_q : S_AXI_AWADDR_I;
    assign wdata_eff = w_got_q ? wdata_q : S_AXI_WDATA_I;
    assign wstrb_eff = w_got_q ? wstrb_q : S_AXI_WSTRB_I;
    assign wr_go     = (wst_q == W_COLLECT) && (aw_got_q || aw_fire) && (w_got_q || w_fire);

    // word-level match against each capability offset
    for (genvar i = 0; i < NCAP; i++) begin : g_cap_hit
        assign cap_hit_w[i] = (waddr_eff[ADDR_W-1:2] == CAP_OFS[i][ADDR_W-1:2]);
        assign cap_hit_r[i] = (S_AXI_ARADDR_I[ADDR_W-1:2] == CAP_OFS[i][ADDR_W-1:2]);
    end

    assign cap_wr_evt = wr_go && (|cap_hit_w);

    // write path: collect address and data in either order, then answer
    always_comb begin
        wst_d      = wst_q;
        aw_got_d   = aw_got_q;
        w_got_d    = w_got_q;
        waddr_d    = waddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bresp_d    = bresp_q;
        ctrl_err_d = ctrl_err_q;
        ign_cnt_d  = ign_cnt_q;
        case (wst_q)
            W_COLLECT: begin
                if (aw_fire) begin
                    aw_got_d = 1'b1;
                    waddr_d  = S_AXI_AWADDR_I;
                end
                if (w_fire) begin
                    w_got_d = 1'b1;
                    wdata_d = S_AXI_WDATA_I;
                    wstrb_d = S_AXI_WSTRB_I;
                end
                if (wr_go) begin
                    aw_got_d = 1'b0;
                    w_got_d  = 1'b0;
                    wst_d    = W_RESP;
                    bresp_d  = RESP_OKAY;
                    if (waddr_eff[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) begin
                        if (wstrb_eff[0]) begin
                            ctrl_err_d = wdata_eff[CTRL_ERR_BIT];
                        end
                    end else if (|cap_hit_w) begin
                        // value untouched, only counted for diagnostics
                        ign_cnt_d = ign_cnt_q + 8'h01; // RQ11
                    end else if (waddr_eff[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) begin
                        bresp_d = RESP_OKAY;
                    end else if (ctrl_err_q) begin
                        bresp_d = RESP_SLVERR;
                    end
                end
            end
            W_RESP: begin
                if (S_AXI_BREADY_I) begin
                    wst_d = W_COLLECT;
                end
            end
            default: wst_d = W_COLLECT;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wst_q      <= W_COLLECT;
            aw_got_q   <= 1'b0;
            w_got_q    <= 1'b0;
            waddr_q    <= '0;
            wdata_q    <= '0;
            wstrb_q    <= '0;
            bresp_q    <= RESP_OKAY;
            ctrl_err_q <= CTRL_RESET;
            ign_cnt_q  <= STAT_RESET;
        end else begin
            wst_q      <= wst_d;
            aw_got_q   <= aw_got_d;
            w_got_q    <= w_got_d;
            waddr_q    <= waddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bresp_q    <= bresp_d;
            ctrl_err_q <= ctrl_err_d;
            ign_cnt_q  <= ign_cnt_d;
        end
    end

    // read path: one cycle from address taken to data valid
    always_comb begin
        rst_d     = rst_q;
        rd_d      = rd_q;
        rd_word_d = rd_word_q;
        case (rst_q)
            R_IDLE: begin
                if (S_AXI_ARVALID_I) begin
                    rst_d     = R_RESP;
                    rd_word_d = S_AXI_ARADDR_I[ADDR_W-1:2];
                    rd_d.data = '0; // RQ10
                    rd_d.resp = RESP_OKAY;
                    if (|cap_hit_r) begin
                        // constant table, bit per rate, upper bits stay zero
                        for (int k = 0; k < NCAP; k++) begin // RQ4 RQ5 RQ6 RQ7 RQ8 RQ9
                            if (cap_hit_r[k]) begin
                                rd_d.data[7:0] = CAP_VAL[k]; // RQ1 RQ2 RQ3
                            end
                        end
                    end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) begin
                        rd_d.data[CTRL_ERR_BIT] = ctrl_err_q;
                    end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) begin
                        rd_d.data[CNT_W-1:0] = ign_cnt_q;
                    end else if (ctrl_err_q) begin
                        rd_d.resp = RESP_SLVERR;
                    end
                end
            end
            R_RESP: begin
                if (S_AXI_RREADY_I) begin
                    rst_d = R_IDLE;
                end
            end
            default: rst_d = R_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rst_q     <= R_IDLE;
            rd_q      <= '0;
            rd_word_q <= '0;
        end else begin
            rst_q     <= rst_d;
            rd_q      <= rd_d;
            rd_word_q <= rd_word_d;
        end
    end

    // decode copies for the checks, kept apart from the datapath
    logic               ar_ctrl_hit, ar_stat_hit, ar_unmapped;
    logic               aw_ctrl_hit, aw_unmapped;
    logic [1:0]         unmap_resp;

    assign ar_ctrl_hit = (S_AXI_ARADDR_I[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]);
    assign ar_stat_hit = (S_AXI_ARADDR_I[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);
    assign ar_unmapped = !(|cap_hit_r) && !ar_ctrl_hit && !ar_stat_hit;
    assign aw_ctrl_hit = (waddr_eff[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]);
    assign aw_unmapped = !(|cap_hit_w) && !aw_ctrl_hit
                         && (waddr_eff[ADDR_W-1:2] != STAT_OFS[ADDR_W-1:2]);
    assign unmap_resp  = ctrl_err_q ? RESP_SLVERR : RESP_OKAY;

    // checks on answers and table contents
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!rst_n_s);

    sequence s_ar_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence

    sequence s_rd_of(logic [ADDR_W-3:0] w);
        S_AXI_RVALID_O && (rd_word_q == w);
    endsequence

    // request steps split by target, so each answer is checked on its own
    sequence s_cap_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && (|cap_hit_r);
    endsequence

    sequence s_unmap_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && ar_unmapped;
    endsequence

    sequence s_stat_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && ar_stat_hit;
    endsequence

    sequence s_ctrl_take;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && ar_ctrl_hit;
    endsequence

    sequence s_rd_okay;
        S_AXI_RVALID_O && (S_AXI_RRESP_O == RESP_OKAY);
    endsequence

    sequence s_wr_unmapped;
        wr_go && aw_unmapped;
    endsequence

    sequence s_ctrl_wr;
        wr_go && aw_ctrl_hit && wstrb_eff[0];
    endsequence

    a_rd_answer_next: assert property (s_ar_take |=> S_AXI_RVALID_O ##0 !S_AXI_ARREADY_O) // RQ2
        else $error("read answer not one cycle after address");
    a_cap_f0m1_val: assert property (s_rd_of(10'h081) |-> S_AXI_RDATA_O == 32'h0000003f) // RQ4
        else $error("wrong value at 0x204");
    a_cap_f0m5_val: assert property (s_rd_of(10'h085) |-> S_AXI_RDATA_O == 32'h0000003f) // RQ5
        else $error("wrong value at 0x214");
    a_cap_f0m6_val: assert property (s_rd_of(10'h086) |-> S_AXI_RDATA_O[5:4] == 2'b01) // RQ6
        else $error("rate order wrong at 0x218");
    a_cap_f0m6_full: assert property (s_rd_of(10'h086) |-> S_AXI_RDATA_O == 32'h0000001f) // RQ3
        else $error("wrong value at 0x218");
    a_cap_f1m2_val: assert property (s_rd_of(10'h08a) |-> S_AXI_RDATA_O == 32'h0000003c) // RQ7
        else $error("wrong value at 0x228");
    a_cap_f1m5_val: assert property (s_rd_of(10'h08d) |-> S_AXI_RDATA_O == 32'h0000001e) // RQ8
        else $error("wrong value at 0x234");
    a_cap_f1m6_val: assert property (s_rd_of(10'h08e) |-> S_AXI_RDATA_O == 32'h0000001e) // RQ9
        else $error("wrong value at 0x238");
    a_rsv_bits_zero: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000) // RQ10
        else $error("reserved bits not zero");
    a_cap_wr_ignored: assert property (cap_wr_evt |=> S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_OKAY
                                       && ign_cnt_q == $past(ign_cnt_q) + 8'h01) // RQ11
        else $error("capability write not ignored cleanly");
    a_wr_resp_next: assert property (wr_go |=> S_AXI_BVALID_O [*1] ##0 !S_AXI_AWREADY_O) // RQ1
        else $error("write answer not one cycle after last half");

    // every table read answers okay; no row offers the two fastest rates
    a_cap_rd_okay: assert property (s_cap_take |=> s_rd_okay) // RQ1
        else $error("capability read not answered okay");
    a_cap_fast_off: assert property (s_cap_take |=> S_AXI_RDATA_O[7:6] == 2'b00) // RQ3
        else $error("fastest rates reported available");

    // unmapped words: zero data, response chosen by the error flag
    a_unmap_rd_resp: assert property (s_unmap_take |=> S_AXI_RDATA_O == 32'h00000000
                                      && S_AXI_RRESP_O == $past(unmap_resp))
        else $error("unmapped read answered wrongly");
    a_unmap_wr_resp: assert property (s_wr_unmapped |=> S_AXI_BVALID_O
                                      && S_AXI_BRESP_O == $past(unmap_resp))
        else $error("unmapped write answered wrongly");

    // own registers: the flag and the ignore counter read back as held
    a_ctrl_rd_flag: assert property (s_ctrl_take |=> S_AXI_RDATA_O[CTRL_ERR_BIT]
                                     == $past(ctrl_err_q))
        else $error("control flag read back wrongly");
    a_ctrl_wr_flag: assert property (s_ctrl_wr |=> ctrl_err_q == $past(wdata_eff[CTRL_ERR_BIT]))
        else $error("control flag not taken from write");
    a_stat_rd_count: assert property (s_stat_take |=> S_AXI_RDATA_O // RQ11
                                      == {{(DATA_W-CNT_W){1'b0}}, $past(ign_cnt_q)})
        else $error("ignore counter read back wrongly");

    // capability writes move nothing but the counter
    a_cnt_steady: assert property (!cap_wr_evt |=> ign_cnt_q == $past(ign_cnt_q)) // RQ11
        else $error("ignore counter moved without a capability write");
    a_cap_wr_no_ctrl: assert property (cap_wr_evt |=> ctrl_err_q == $past(ctrl_err_q)) // RQ11
        else $error("capability write changed the control flag");

endmodule
`default_nettype wire

// ### frirq_host.sv
// Purpose: AXI4-Lite host model that reads and writes the rate bank
// Assumes: one request at a time, driven right after a rising edge
// Notes:   released address and data lines show the inverse value
`timescale 1ns/100ps
`default_nettype none
module frirq_host
    import frirq_pkg::*;
(
    // clock
    input  wire logic         MCLK_I,
    // write channels
    output logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    output logic              S_AXI_AWVALID_I,
    input  wire logic         S_AXI_AWREADY_O,
    output logic [DATA_W-1:0] S_AXI_WDATA_I,
    output logic [3:0]        S_AXI_WSTRB_I,
    output logic              S_AXI_WVALID_I,
    input  wire logic         S_AXI_WREADY_O,
    input  wire logic [1:0]   S_AXI_BRESP_O,
    input  wire logic         S_AXI_BVALID_O,
    output logic              S_AXI_BREADY_I,
    // read channels
    output logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    output logic              S_AXI_ARVALID_I,
    input  wire logic         S_AXI_ARREADY_O,
    input  wire logic [DATA_W-1:0] S_AXI_RDATA_O,
    input  wire logic [1:0]   S_AXI_RRESP_O,
    input  wire logic         S_AXI_RVALID_O,
    output logic              S_AXI_RREADY_I
);
    // idle bus at time zero
    initial begin
        S_AXI_AWVALID_I = 1'b0;
        S_AXI_WVALID_I  = 1'b0;
        S_AXI_BREADY_I  = 1'b0;
        S_AXI_ARVALID_I = 1'b0;
        S_AXI_RREADY_I  = 1'b0;
        S_AXI_AWADDR_I  = '0;
        S_AXI_WDATA_I   = '0;
        S_AXI_WSTRB_I   = 4'h0;
        S_AXI_ARADDR_I  = '0;
    end

    // write: both halves offered at once, each dropped when taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge MCLK_I);
        S_AXI_AWADDR_I  <= a;
        S_AXI_WDATA_I   <= d;
        S_AXI_WSTRB_I   <= 4'hf;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I  <= 1'b1;
        S_AXI_BREADY_I  <= 1'b1;
        while (!done) begin
            @(posedge MCLK_I);
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                S_AXI_AWVALID_I <= 1'b0;
                S_AXI_AWADDR_I  <= ~a;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                S_AXI_WVALID_I <= 1'b0;
                S_AXI_WDATA_I  <= ~d;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                r = S_AXI_BRESP_O;
                S_AXI_BREADY_I <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // read: rready held from the start so the answer is taken at once
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge MCLK_I);
        S_AXI_ARADDR_I  <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I  <= 1'b1;
        while (!done) begin
            @(posedge MCLK_I);
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_ARVALID_I <= 1'b0;
                S_AXI_ARADDR_I  <= ~a;
            end
            if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                d = S_AXI_RDATA_O;
                r = S_AXI_RRESP_O;
                S_AXI_RREADY_I <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### frirq_regs_tb.sv
// Purpose: self-checking bench for the frame rate capability bank
// Assumes: host model tasks drive the AXI4-Lite port
// Notes:   expected words are written out here, not taken from the design
`timescale 1ns/100ps
`default_nettype none
module frirq_regs_tb;
    import frirq_pkg::*;
    // bus wires shared by design and host model
    logic MCLK_I, RESETN_I;
    logic [ADDR_W-1:0] S_AXI_AWADDR_I, S_AXI_ARADDR_I;
    logic [DATA_W-1:0] S_AXI_WDATA_I, S_AXI_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O;
    logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O;
    logic S_AXI_RVALID_O, S_AXI_RREADY_I;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // expected words, lowest offset first
    localparam logic [11:0] OFS [0:5] =
        '{12'h204, 12'h214, 12'h218, 12'h228, 12'h234, 12'h238};
    localparam logic [31:0] EXP [0:5] =
        '{32'h3f, 32'h3f, 32'h1f, 32'h3c, 32'h1e, 32'h1e};

    frirq_regs dut_u (.*);
    frirq_host host_u (.*);

    // free-running clock
    initial begin
        MCLK_I = 1'b0;
        forever #5 MCLK_I = ~MCLK_I;
    end

    // hang guard, far above the roughly one hundred and ten cycles needed
    always @(posedge MCLK_I) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        host_u.rd(a, d, r);
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        host_u.wr(a, d, r);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        RESETN_I = 1'b0;
        repeat (4) @(posedge MCLK_I);
        RESETN_I <= 1'b1;
        repeat (3) @(posedge MCLK_I);
        // every word back to back, aligned then with low bits set
        for (int i = 0; i < 6; i++) begin
            rd_chk(OFS[i], EXP[i], RESP_OKAY);
            rd_chk(OFS[i] | 12'h3, EXP[i], RESP_OKAY);
        end
        $display("test read map done");
        // writes answer okay but leave the words alone
        for (int i = 0; i < 6; i++) begin
            wr_chk(OFS[i], 32'hffffffff, RESP_OKAY);
            rd_chk(OFS[i], EXP[i], RESP_OKAY);
        end
        rd_chk(STAT_OFS, 32'h6, RESP_OKAY);
        $display("test write ignore done");
        // unmapped neighbours: error first, plain once errors are off
        rd_chk(CTRL_OFS, 32'h1, RESP_OKAY);
        rd_chk(12'h200, 32'h0, RESP_SLVERR);
        wr_chk(12'h200, 32'h0, RESP_SLVERR);
        wr_chk(CTRL_OFS, 32'h0, RESP_OKAY);
        rd_chk(CTRL_OFS, 32'h0, RESP_OKAY);
        rd_chk(12'h23c, 32'h0, RESP_OKAY);
        wr_chk(12'h23c, 32'h0, RESP_OKAY);
        // the counter itself is read-only
        wr_chk(STAT_OFS, 32'hff, RESP_OKAY);
        rd_chk(STAT_OFS, 32'h6, RESP_OKAY);
        $display("test unmapped done");
        finish_test();
    end
endmodule
`default_nettype wire
